// ==== fwsf_map.svh ====
// Named offsets, field positions, command bytes and timing counts for the status poller
`ifndef FWSF_MAP_SVH
`define FWSF_MAP_SVH
// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define FWSF_CLK_MHZ 20
`define FWSF_T_WP_NS 60
`define FWSF_WP_CYC ((`FWSF_T_WP_NS * `FWSF_CLK_MHZ + 999) / 1000)
`define FWSF_T_ACC_NS 100
`define FWSF_ACC_CYC ((`FWSF_T_ACC_NS * `FWSF_CLK_MHZ + 999) / 1000)
`define FWSF_SYNC_CYC 4
`define FWSF_WR_END (2 * `FWSF_WP_CYC)
`define FWSF_RD_MIN (`FWSF_ACC_CYC + `FWSF_SYNC_CYC)
`define FWSF_BEAT_W 4
`define FWSF_T_GAP_US 80
`define FWSF_GAP_CYC ((`FWSF_T_GAP_US * `FWSF_CLK_MHZ) - 16)
`define FWSF_GAP_W 11
// ----------------------------------------------------------------
// Register word offsets and status bit positions
// ----------------------------------------------------------------
`define FWSF_REG_CTRL 3'h0
`define FWSF_REG_ADDR 3'h1
`define FWSF_REG_WDATA 3'h2
`define FWSF_REG_STATUS 3'h3
`define FWSF_REG_RDATA 3'h4
`define FWSF_ST_BUSY 0
`define FWSF_ST_DONE 1
`define FWSF_ST_FAIL 2
`define FWSF_ST_REFUSED 3
`define FWSF_ST_ERASE_PEND 4
`define FWSF_ST_WIN_OPEN 5
`define FWSF_ST_READY 6
`define FWSF_ST_NOT_ACC 7
`define FWSF_ST_ZERO_TO_ONE 8
`define FWSF_ST_TIMEOUT 9
// ----------------------------------------------------------------
// Flash status bits, commands and step counts
// ----------------------------------------------------------------
`define FWSF_DQ_POLL 7
`define FWSF_DQ_TIMEOUT 5
`define FWSF_DQ_WINDOW 3
`define FWSF_UNLOCK1_ADDR 20'h0_0555
`define FWSF_UNLOCK2_ADDR 20'h0_02AA
`define FWSF_CMD_UNLOCK1 8'hAA
`define FWSF_CMD_UNLOCK2 8'h55
`define FWSF_CMD_PROG 8'hA0
`define FWSF_CMD_ERASE 8'h80
`define FWSF_CMD_CHIP 8'h10
`define FWSF_CMD_SECTOR 8'h30
`define FWSF_CMD_RESET 8'hF0
`define FWSF_ERASED 8'hFF
`define FWSF_STEP_PROG_LAST 3'h3
`define FWSF_STEP_ERASE_LAST 3'h5
`define FWSF_STEP_FIRST 3'h0
`endif

// ==== fwsf_pkg.sv ====
// Types shared by the status poller: states, operations and the flash pin bundle
package fwsf_pkg;
  typedef enum logic [2:0] {
    FWSF_IDLE = 3'h0,
    FWSF_PRE = 3'h1,
    FWSF_WRC = 3'h3,
    FWSF_POLL = 3'h2,
    FWSF_CHK = 3'h6,
    FWSF_RERD = 3'h7,
    FWSF_FIN = 3'h5
  } fwsf_state_t;

  typedef enum logic [2:0] {
    FWSF_OP_NONE = 3'h0,
    FWSF_OP_PROG = 3'h1,
    FWSF_OP_CHIP = 3'h2,
    FWSF_OP_SECT = 3'h3,
    FWSF_OP_ADD = 3'h4,
    FWSF_OP_READ = 3'h5,
    FWSF_OP_RESET = 3'h6,
    FWSF_OP_WAIT = 3'h7
  } fwsf_op_t;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [19:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
  } fwsf_pins_t;
endpackage : fwsf_pkg

// ==== fwsf_ctrl.sv ====
// Host controller that issues flash program/erase sequences and polls write status
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fwsf_map.svh"
// How it works
// - Poll reads always use the address of the programmed or erased location.
// - Poll success is confirmed by one more read before data is trusted.
// - Never program a 0 back to 1; reset the flash after a timeout.
// - Check erase-window bit after each sector command; keep command gaps under 80 us.
module fwsf_ctrl (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output fwsf_pkg::fwsf_pins_t flash_pins,
  input wire logic [7:0] flash_dq_i,
  input wire logic flash_ready_busy_i
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address and data of one command-sequence write
  function automatic logic [27:0] cmd_step(input fwsf_pkg::fwsf_op_t op, input logic [2:0] st,
                                           input logic [19:0] a, input logic [7:0] d);
    logic [27:0] r;
    r = {`FWSF_UNLOCK1_ADDR, `FWSF_CMD_RESET};
    if (op != fwsf_pkg::FWSF_OP_RESET) begin
      unique case (st)
        3'h0: r = {`FWSF_UNLOCK1_ADDR, `FWSF_CMD_UNLOCK1};
        3'h1: r = {`FWSF_UNLOCK2_ADDR, `FWSF_CMD_UNLOCK2};
        3'h2: r = (op == fwsf_pkg::FWSF_OP_PROG) ? {`FWSF_UNLOCK1_ADDR, `FWSF_CMD_PROG} :
                                                   {`FWSF_UNLOCK1_ADDR, `FWSF_CMD_ERASE};
        3'h3: r = (op == fwsf_pkg::FWSF_OP_PROG) ? {a, d} : {`FWSF_UNLOCK1_ADDR, `FWSF_CMD_UNLOCK1};
        3'h4: r = {`FWSF_UNLOCK2_ADDR, `FWSF_CMD_UNLOCK2};
        default: r = (op == fwsf_pkg::FWSF_OP_CHIP) ? {`FWSF_UNLOCK1_ADDR, `FWSF_CMD_CHIP} :
                                                     {a, `FWSF_CMD_SECTOR};
      endcase
    end
    return r;
  endfunction : cmd_step

  // Data-poll completion test: true bit 7 for program, 1 for erase
  function automatic logic poll_done(input fwsf_pkg::fwsf_op_t op, input logic [7:0] b,
                                     input logic [7:0] wd);
    return (op == fwsf_pkg::FWSF_OP_PROG) ? (b[`FWSF_DQ_POLL] == wd[`FWSF_DQ_POLL]) :
                                            b[`FWSF_DQ_POLL];
  endfunction : poll_done

  fwsf_pkg::fwsf_state_t st_q;
  fwsf_pkg::fwsf_op_t op_q;
  fwsf_pkg::fwsf_op_t op_in;
  fwsf_pkg::fwsf_pins_t pins_d;
  logic ack_q, wr_acc, rd_acc, start, accept, beat_done, wr_phase, done_now;
  logic [19:0] addr_q;
  logic [7:0] wdata_q, rdata_q, old_q;
  logic [7:0] dq_s1, dq_s2, dq_s3;
  logic [2:0] rb_s;
  logic rb_q;
  logic [2:0] step_q, last_step;
  logic [`FWSF_BEAT_W-1:0] cnt_q;
  logic [`FWSF_GAP_W-1:0] gap_q;
  logic [27:0] cmd;
  logic done_q, fail_q, refused_q, erase_pend_q, win_open_q, not_acc_q, z2o_q, to_q;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait cycle per access keeps read data registered
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_acc = avs_write & ack_q;
  assign rd_acc = avs_read & ack_q;
  assign start = wr_acc && (avs_address == `FWSF_REG_CTRL);
  assign op_in = fwsf_pkg::fwsf_op_t'(avs_writedata[2:0]);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // Writable parameters of the next operation, frozen while busy
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 20'h0_0000;
      wdata_q <= 8'h00;
    end else if (wr_acc && st_q == fwsf_pkg::FWSF_IDLE) begin
      if (avs_address == `FWSF_REG_ADDR) addr_q <= avs_writedata[19:0];
      if (avs_address == `FWSF_REG_WDATA) wdata_q <= avs_writedata[7:0];
    end
  end

  // Read mux; unmapped words read as zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      avs_readdata <= 32'h0000_0000;
      unique case (avs_address)
        `FWSF_REG_ADDR: avs_readdata[19:0] <= addr_q;
        `FWSF_REG_WDATA: avs_readdata[7:0] <= wdata_q;
        `FWSF_REG_RDATA: avs_readdata[7:0] <= rdata_q;
        `FWSF_REG_STATUS: begin
          avs_readdata[`FWSF_ST_BUSY] <= (st_q != fwsf_pkg::FWSF_IDLE);
          avs_readdata[`FWSF_ST_DONE] <= done_q;
          avs_readdata[`FWSF_ST_FAIL] <= fail_q;
          avs_readdata[`FWSF_ST_REFUSED] <= refused_q;
          avs_readdata[`FWSF_ST_ERASE_PEND] <= erase_pend_q;
          avs_readdata[`FWSF_ST_WIN_OPEN] <= win_open_q;
          avs_readdata[`FWSF_ST_READY] <= rb_q;
          avs_readdata[`FWSF_ST_NOT_ACC] <= not_acc_q;
          avs_readdata[`FWSF_ST_ZERO_TO_ONE] <= z2o_q;
          avs_readdata[`FWSF_ST_TIMEOUT] <= to_q;
        end
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Data and ready/busy are asynchronous; a value counts once stages two and three agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      dq_s3 <= 8'h00;
      rb_s <= 3'h0;
      rb_q <= 1'b0;
    end else begin
      dq_s1 <= flash_dq_i;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      rb_s <= {rb_s[1:0], flash_ready_busy_i};
      if (rb_s[1] == rb_s[2]) rb_q <= rb_s[2];
    end
  end

  // ----------------------------------------------------------------
  // Bus beat engine
  // ----------------------------------------------------------------
  // Each beat starts with an idle cycle so the flash output never meets our drive
  assign wr_phase = (st_q == fwsf_pkg::FWSF_WRC);
  assign beat_done = wr_phase ? (cnt_q == `FWSF_BEAT_W'(`FWSF_WR_END)) :
                     (cnt_q >= `FWSF_BEAT_W'(`FWSF_RD_MIN) && dq_s2 == dq_s3);
  assign cmd = cmd_step(op_q, step_q, addr_q, wdata_q);
  assign last_step = (op_q == fwsf_pkg::FWSF_OP_PROG) ? `FWSF_STEP_PROG_LAST :
                     (op_q == fwsf_pkg::FWSF_OP_RESET) ? `FWSF_STEP_FIRST : `FWSF_STEP_ERASE_LAST;
  assign done_now = poll_done(op_q, dq_s3, wdata_q);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (beat_done || st_q == fwsf_pkg::FWSF_IDLE || st_q == fwsf_pkg::FWSF_CHK ||
                 st_q == fwsf_pkg::FWSF_FIN) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + `FWSF_BEAT_W'(1);
    end
  end

  // Pin levels; reads always sit on the operation address
  always_comb begin
    pins_d = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: addr_q, dq_o: 8'h00, dq_oe: 1'b0};
    if (wr_phase) begin
      pins_d.addr = cmd[27:8];
      pins_d.dq_o = cmd[7:0];
      if (cnt_q != '0 && cnt_q <= `FWSF_BEAT_W'(`FWSF_WP_CYC)) begin
        pins_d.ce_n = 1'b0;
        pins_d.we_n = 1'b0;
        pins_d.dq_oe = 1'b1;
      end
    end else if ((st_q == fwsf_pkg::FWSF_PRE || st_q == fwsf_pkg::FWSF_POLL ||
                  st_q == fwsf_pkg::FWSF_RERD) && cnt_q != '0) begin
      pins_d.ce_n = 1'b0;
      pins_d.oe_n = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flash_pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h0_0000, dq_o: 8'h00,
                      dq_oe: 1'b0};
    end else begin
      flash_pins <= pins_d;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Adding a sector is refused once the gap is near its limit, since the flash would drop it
  assign accept = start && st_q == fwsf_pkg::FWSF_IDLE && op_in != fwsf_pkg::FWSF_OP_NONE &&
                  (op_in != fwsf_pkg::FWSF_OP_WAIT || erase_pend_q) &&
                  (op_in != fwsf_pkg::FWSF_OP_ADD ||
                   (erase_pend_q && win_open_q && gap_q < `FWSF_GAP_W'(`FWSF_GAP_CYC)));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= fwsf_pkg::FWSF_IDLE;
      op_q <= fwsf_pkg::FWSF_OP_NONE;
      step_q <= `FWSF_STEP_FIRST;
      rdata_q <= 8'h00;
      old_q <= 8'h00;
    end else begin
      unique case (st_q)
        fwsf_pkg::FWSF_IDLE: if (accept) begin
          op_q <= op_in;
          step_q <= (op_in == fwsf_pkg::FWSF_OP_ADD) ? `FWSF_STEP_ERASE_LAST : `FWSF_STEP_FIRST;
          unique case (op_in)
            fwsf_pkg::FWSF_OP_PROG: st_q <= fwsf_pkg::FWSF_PRE;
            fwsf_pkg::FWSF_OP_WAIT: st_q <= fwsf_pkg::FWSF_POLL;
            fwsf_pkg::FWSF_OP_READ: st_q <= fwsf_pkg::FWSF_RERD;
            default: st_q <= fwsf_pkg::FWSF_WRC;
          endcase
        end
        // Read the target first so no bit is asked to go from 0 to 1
        fwsf_pkg::FWSF_PRE: if (beat_done) begin
          old_q <= dq_s3;
          st_q <= ((~dq_s3 & wdata_q) != 8'h00) ? fwsf_pkg::FWSF_FIN : fwsf_pkg::FWSF_WRC;
        end
        fwsf_pkg::FWSF_WRC: if (beat_done) begin
          step_q <= step_q + 3'h1;
          if (step_q == last_step) begin
            st_q <= (op_q == fwsf_pkg::FWSF_OP_RESET) ? fwsf_pkg::FWSF_FIN : fwsf_pkg::FWSF_POLL;
          end
        end
        fwsf_pkg::FWSF_POLL: if (beat_done) begin
          rdata_q <= dq_s3;
          st_q <= fwsf_pkg::FWSF_CHK;
        end
        // A window check after a sector command ends the order; erase goes on in the flash
        fwsf_pkg::FWSF_CHK: begin
          if (op_q == fwsf_pkg::FWSF_OP_SECT || op_q == fwsf_pkg::FWSF_OP_ADD) begin
            st_q <= fwsf_pkg::FWSF_FIN;
          end else if (poll_done(op_q, rdata_q, wdata_q) || rdata_q[`FWSF_DQ_TIMEOUT]) begin
            st_q <= fwsf_pkg::FWSF_RERD;
          end else begin
            st_q <= fwsf_pkg::FWSF_POLL;
          end
        end
        // Bit 7 may flip before the rest of the byte, so trust only this second read
        fwsf_pkg::FWSF_RERD: if (beat_done) begin
          rdata_q <= dq_s3;
          if (op_q == fwsf_pkg::FWSF_OP_READ || done_now) begin
            st_q <= fwsf_pkg::FWSF_FIN;
          end else if (to_q) begin
            op_q <= fwsf_pkg::FWSF_OP_RESET;
            step_q <= `FWSF_STEP_FIRST;
            st_q <= fwsf_pkg::FWSF_WRC;
          end else begin
            st_q <= fwsf_pkg::FWSF_POLL;
          end
        end
        fwsf_pkg::FWSF_FIN: st_q <= fwsf_pkg::FWSF_IDLE;
        default: st_q <= fwsf_pkg::FWSF_IDLE;
      endcase
    end
  end

  // Result flags; an accepted order clears them, a refused start sets refused, and only the busy sequencer sets the rest
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      refused_q <= 1'b0;
      not_acc_q <= 1'b0;
      z2o_q <= 1'b0;
      to_q <= 1'b0;
    end else if (accept) begin
      {done_q, fail_q, refused_q, not_acc_q, z2o_q, to_q} <= 6'h00;
    end else begin
      if (start && !accept) refused_q <= 1'b1;
      if (st_q == fwsf_pkg::FWSF_FIN) done_q <= 1'b1;
      if (st_q == fwsf_pkg::FWSF_PRE && beat_done && (~dq_s3 & wdata_q) != 8'h00) begin
        z2o_q <= 1'b1;
        fail_q <= 1'b1;
      end
      if (st_q == fwsf_pkg::FWSF_CHK && rdata_q[`FWSF_DQ_TIMEOUT] &&
          op_q != fwsf_pkg::FWSF_OP_SECT && op_q != fwsf_pkg::FWSF_OP_ADD) begin
        to_q <= 1'b1;
      end
      if (st_q == fwsf_pkg::FWSF_CHK && op_q == fwsf_pkg::FWSF_OP_ADD && rdata_q[`FWSF_DQ_WINDOW]) begin
        not_acc_q <= 1'b1;
      end
      if (st_q == fwsf_pkg::FWSF_RERD && beat_done && op_q != fwsf_pkg::FWSF_OP_READ &&
          (done_now ? (dq_s3 != ((op_q == fwsf_pkg::FWSF_OP_PROG) ? wdata_q : `FWSF_ERASED)) : to_q)) begin
        fail_q <= 1'b1;
      end
    end
  end

  // Sector-erase bookkeeping: pending erase, open window and the gap since the last erase command
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      erase_pend_q <= 1'b0;
      win_open_q <= 1'b0;
      gap_q <= '0;
    end else begin
      if (accept && op_in == fwsf_pkg::FWSF_OP_SECT) erase_pend_q <= 1'b1;
      if (st_q == fwsf_pkg::FWSF_FIN && op_q != fwsf_pkg::FWSF_OP_SECT &&
          op_q != fwsf_pkg::FWSF_OP_ADD && op_q != fwsf_pkg::FWSF_OP_READ) erase_pend_q <= 1'b0;
      if (st_q == fwsf_pkg::FWSF_CHK && (op_q == fwsf_pkg::FWSF_OP_SECT || op_q == fwsf_pkg::FWSF_OP_ADD)) begin
        win_open_q <= ~rdata_q[`FWSF_DQ_WINDOW];
      end else if (gap_q == `FWSF_GAP_W'(`FWSF_GAP_CYC)) begin
        win_open_q <= 1'b0;
      end
      if (wr_phase && beat_done && step_q == `FWSF_STEP_ERASE_LAST) gap_q <= '0;
      else if (gap_q != `FWSF_GAP_W'(`FWSF_GAP_CYC)) gap_q <= gap_q + `FWSF_GAP_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_poll_addr;
    @(posedge clock) disable iff (!reset_n)
      !flash_pins.oe_n |-> (flash_pins.addr == addr_q) && flash_pins.we_n && !flash_pins.dq_oe;
  endproperty
  a_poll_addr: assert property (p_poll_addr) else $error("read not at operation address");

  property p_reread;
    @(posedge clock) disable iff (!reset_n)
      (st_q == fwsf_pkg::FWSF_CHK && op_q == fwsf_pkg::FWSF_OP_PROG && poll_done(op_q, rdata_q, wdata_q))
      |=> st_q == fwsf_pkg::FWSF_RERD ##1 (st_q == fwsf_pkg::FWSF_RERD)[*2] ##[1:40] !flash_pins.oe_n;
  endproperty
  a_reread: assert property (p_reread) else $error("poll success not confirmed by reread");

  property p_no_zero_to_one;
    @(posedge clock) disable iff (!reset_n)
      (wr_phase && op_q == fwsf_pkg::FWSF_OP_PROG && step_q == `FWSF_STEP_PROG_LAST && !pins_d.we_n)
      |-> ((~old_q & wdata_q) == 8'h00);
  endproperty
  a_no_zero_to_one: assert property (p_no_zero_to_one) else $error("program would set 0 to 1");

  property p_reset_after_timeout;
    @(posedge clock) disable iff (!reset_n)
      (st_q == fwsf_pkg::FWSF_RERD && beat_done && to_q && !done_now &&
       op_q != fwsf_pkg::FWSF_OP_READ) |=> ##[1:20] (!pins_d.we_n && pins_d.dq_o == `FWSF_CMD_RESET);
  endproperty
  a_reset_after_timeout: assert property (p_reset_after_timeout) else $error("no reset after timeout");

  property p_window_check;
    @(posedge clock) disable iff (!reset_n)
      (wr_phase && beat_done && step_q == `FWSF_STEP_ERASE_LAST && op_q != fwsf_pkg::FWSF_OP_CHIP)
      |=> st_q == fwsf_pkg::FWSF_POLL ##[2:40] st_q == fwsf_pkg::FWSF_CHK;
  endproperty
  a_window_check: assert property (p_window_check) else $error("no window check after sector");

  property p_gap_limit;
    @(posedge clock) disable iff (!reset_n)
      (accept && op_in == fwsf_pkg::FWSF_OP_ADD) |-> $past(win_open_q) && gap_q < `FWSF_GAP_W'(`FWSF_GAP_CYC);
  endproperty
  a_gap_limit: assert property (p_gap_limit) else $error("sector added after gap limit");

  c_prog: cover property (@(posedge clock) disable iff (!reset_n)
    op_q == fwsf_pkg::FWSF_OP_PROG && st_q == fwsf_pkg::FWSF_FIN && !fail_q);
  c_add: cover property (@(posedge clock) disable iff (!reset_n)
    op_q == fwsf_pkg::FWSF_OP_ADD && st_q == fwsf_pkg::FWSF_FIN);
  c_timeout: cover property (@(posedge clock) disable iff (!reset_n)
    op_q == fwsf_pkg::FWSF_OP_RESET && to_q && st_q == fwsf_pkg::FWSF_FIN);
endmodule : fwsf_ctrl

// ==== fwsf_flash_model.sv ====
// Behavioural flash partner: command decode, busy timing and write status bits
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Flash model
// ----------------------------------------------------------------
module fwsf_flash_model #(
  parameter int BUSY_NS = 5000,
  parameter int WIN_NS = 80000,
  parameter int PROT_NS = 1000,
  parameter logic [1:0] PROT_SEC = 2'h3
) (
  input wire fwsf_pkg::fwsf_pins_t pins,
  input wire logic fail_mode,
  output logic [7:0] dq,
  output logic rb_low
);
  logic [7:0] mem [0:255];
  logic [7:0] last, cmd, stat, rd_val;
  logic busy, erase, win, fail, stale, tog, tog2;
  int step;
  logic [3:0] esec;
  realtime done_at;
  wire wr_act = !pins.ce_n && !pins.we_n && pins.oe_n;
  wire rd_act = !pins.ce_n && !pins.oe_n;
  // Power-up: erased array, read mode
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {busy, erase, win, fail, stale, tog, tog2, rb_low} = 8'h00;
    step = 0;
    esec = 4'h0;
  end
  // Status byte: poll, toggle, timeout, window, sector toggle
  assign stat = {~erase & ~last[7], tog, fail, 1'b0, erase & ~win, ~erase | tog2, 2'b00};
  // The first read after completion may carry true bit 7 with stale low bits
  assign rd_val = busy ? stat : (stale ? {mem[pins.addr[7:0]][7], stat[6:0]} : mem[pins.addr[7:0]]);
  // Released bus shows the inverse so a stale sample never looks valid
  assign dq = rd_act ? rd_val : ~rd_val;
  task automatic begin_op(input logic e, input realtime t);
    busy = 1'b1;
    erase = e;
    rb_low = 1'b1;
    done_at = $realtime + t;
    step = 0;
  endtask : begin_op
  // Command decode at the end of each write strobe
  always @(negedge wr_act) begin
    if (fail && pins.dq_o == 8'hF0) begin
      {busy, erase, win, fail, rb_low} = 5'h00;
    end else if (busy) begin
      if (win && pins.dq_o == 8'h30) begin
        done_at = $realtime + WIN_NS + BUSY_NS;
        esec[pins.addr[7:6]] = 1'b1;
      end
    end else if (step == 3 && cmd == 8'hA0) begin
      last = pins.dq_o;
      // A protected sector keeps its byte and looks busy only briefly
      if (pins.addr[7:6] != PROT_SEC) mem[pins.addr[7:0]] &= pins.dq_o;
      begin_op(1'b0, (pins.addr[7:6] == PROT_SEC) ? PROT_NS : BUSY_NS);
    end else if (step == 5 && (pins.dq_o == 8'h10 || pins.dq_o == 8'h30)) begin
      win = (pins.dq_o == 8'h30);
      esec = win ? (4'h1 << pins.addr[7:6]) : 4'hF;
      begin_op(1'b1, BUSY_NS + (win ? WIN_NS : 0));
    end else if (step == 2) begin
      cmd = pins.dq_o;
      step = 3;
    end else if (pins.dq_o == ((step % 3 == 0) ? 8'hAA : 8'h55)) begin
      step = step + 1;
    end else begin
      step = 0;
    end
  end
  // Embedded timing; a forced failure stays busy until a reset command
  always #10 if (busy) begin
    if (win && $realtime >= done_at - BUSY_NS) win = 1'b0;
    if (!win && $realtime >= done_at && fail_mode) fail = 1'b1;
    if (!win && $realtime >= done_at && !fail_mode) begin
      if (erase) foreach (mem[i]) mem[i] = 8'hFF;
      {busy, erase, rb_low, stale} = 4'h1;
    end
  end
  // Each read access while busy counts once for toggle bit 6, and for bit 2 only in a sector being erased
  always @(posedge rd_act) if (busy) begin
    tog = ~tog;
    tog2 = tog2 ^ (erase & esec[pins.addr[7:6]]);
  end
  always @(negedge rd_act) if (!busy) stale = 1'b0;
endmodule : fwsf_flash_model

// ==== test_flash_write_status_flags.sv ====
// Self-checking bench for the status poller against the flash model
`timescale 1ns/1ps
`include "fwsf_map.svh"
module test_flash_write_status_flags;
  logic clock, reset_n, avs_read, avs_write, avs_waitrequest, fail_mode, rb_low;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] fdq;
  fwsf_pkg::fwsf_pins_t flash_pins;
  int bad_count, comparisons, cycles;
  fwsf_ctrl dut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_pins(flash_pins),
    .flash_dq_i(flash_pins.dq_oe ? flash_pins.dq_o : fdq), .flash_ready_busy_i(~rb_low));
  fwsf_flash_model flash (.pins(flash_pins), .fail_mode(fail_mode), .dq(fdq), .rb_low(rb_low));
  // ----------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Longest run is two erase windows plus polling, far below this
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // Issue an order, poll until not busy, then judge the masked status
  task automatic run_op(input logic [2:0] op, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b1, `FWSF_REG_CTRL, {29'h0000_0000, op});
    do bus(1'b0, `FWSF_REG_STATUS, 32'h0000_0000); while (q[`FWSF_ST_BUSY] !== 1'b0);
    check("status", q & mask, exp);
  endtask : run_op
  task automatic setup(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, `FWSF_REG_ADDR, {24'h00_0000, a});
    bus(1'b1, `FWSF_REG_WDATA, {24'h00_0000, d});
  endtask : setup
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_program();
    setup(8'h12, 8'h5A);
    run_op(3'h1, 32'h0000_034F, 32'h0000_0042);
    run_op(3'h5, 32'h0000_0001, 32'h0000_0000);
    bus(1'b0, `FWSF_REG_RDATA, 32'h0000_0000);
    check("read back", q, 32'h0000_005A);
    setup(8'h12, 8'hA5);
    run_op(3'h1, 32'h0000_0106, 32'h0000_0106);
    check("array kept", {24'h00_0000, flash.mem[8'h12]}, 32'h0000_005A);
    // Protected sector: brief busy, byte unchanged, so the reread mismatches
    setup(8'hC4, 8'hA5);
    run_op(3'h1, 32'h0000_0106, 32'h0000_0006);
    check("protected kept", {24'h00_0000, flash.mem[8'hC4]}, 32'h0000_00FF);
    run_op(3'h0, 32'h0000_0008, 32'h0000_0008);
    bus(1'b0, 3'h7, 32'h0000_0000);
    check("unmapped", q, 32'h0000_0000);
    $display("done: program and refusals");
  endtask : t_program
  task automatic t_erase();
    run_op(3'h2, 32'h0000_0347, 32'h0000_0042);
    check("chip erased", {24'h00_0000, flash.mem[8'h12]}, 32'h0000_00FF);
    setup(8'h40, 8'h00);
    run_op(3'h3, 32'h0000_0036, 32'h0000_0032);
    setup(8'h80, 8'h00);
    run_op(3'h4, 32'h0000_00BE, 32'h0000_0032);
    run_op(3'h7, 32'h0000_0036, 32'h0000_0002);
    run_op(3'h4, 32'h0000_0008, 32'h0000_0008);
    $display("done: erase");
  endtask : t_erase
  task automatic t_timeout();
    fail_mode <= 1'b1;
    setup(8'h20, 8'h00);
    run_op(3'h1, 32'h0000_0206, 32'h0000_0206);
    check("flash freed", {31'h0000_0000, flash.busy}, 32'h0000_0000);
    fail_mode <= 1'b0;
    $display("done: timeout");
  endtask : t_timeout
  // Reset, register reset values, then the scenarios
  initial begin
    {avs_read, avs_write, fail_mode, reset_n} = 4'h0;
    avs_address = 3'h0;
    avs_writedata = 32'h0000_0000;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    // The ready pin needs its three-stage synchroniser to settle before it reads high
    repeat (4) @(posedge clock);
    bus(1'b0, `FWSF_REG_STATUS, 32'h0000_0000);
    check("status at reset", q & 32'h0000_03FF, 32'h0000_0040);
    t_program();
    t_erase();
    t_timeout();
    close_out();
  end
endmodule : test_flash_write_status_flags
